// [include/adcph_params.svh]
// Constants for the converter host port: geometry, widths, reset values, timing
`ifndef ADCPH_PARAMS_SVH
`define ADCPH_PARAMS_SVH

// Bus and channel geometry
`define ADCPH_DATA_W       12
`define ADCPH_CFG_W        8
`define ADCPH_CHANNELS     8
`define ADCPH_CH_W         3
// Configuration after reset: every channel selected
`define ADCPH_CFG_RESET    8'hff
// Time to convert one channel, in ns, and the clock rate in MHz
`define ADCPH_CONV_NS      100
`define ADCPH_CLK_MHZ      250
// Width of the per-channel conversion timer
`define ADCPH_CNT_W        8
// Conversion cycles per channel, a least time so rounded up
`define ADCPH_CONV_CYC ((`ADCPH_CONV_NS * `ADCPH_CLK_MHZ + 999) / 1000)

`endif

// [include/adcph_pkg.sv]
// Types shared by the converter host port design files
`default_nettype none
package adcph_pkg;
`include "adcph_params.svh"

   // Sequencer states
   typedef enum logic [1:0] {
      ADCPH_IDLE,
      ADCPH_CONV,
      ADCPH_DONE
   } adcph_state_t;

   typedef logic [`ADCPH_DATA_W-1:0] adcph_word_t;

   // Host-side strobes, all active low
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
   } adcph_strobe_t;

   // Data bus output and enable pair; only low lines have an input
   typedef struct packed {
      adcph_word_t                 dout;
      adcph_word_t                 oe;
   } adcph_bus_out_t;

   // Write port into the result memory
   typedef struct packed {
      logic                        we;
      logic [`ADCPH_CH_W-1:0]      addr;
      adcph_word_t                 data;
   } adcph_wr_t;

endpackage : adcph_pkg
`default_nettype wire

// [hdl/adcph_result_mem.sv]
// Result memory: one word per channel, registered read data
`default_nettype none
`include "adcph_params.svh"
module adcph_result_mem #(
   parameter int DEPTH  = `ADCPH_CHANNELS,
   parameter int AW     = `ADCPH_CH_W
) (
   // Clock and reset
   input  wire logic                 clk_in,
   input  wire logic                 reset_n_in,
   // Write port
   input  wire adcph_pkg::adcph_wr_t wr_in,
   // Read port
   input  wire logic [AW-1:0]        raddr_in,
   output var  adcph_pkg::adcph_word_t rdata_out
);
   import adcph_pkg::*;

   adcph_word_t mem_q [DEPTH];       // Stored results

   // Write on strobe; no reset so the array maps onto RAM
   always_ff @(posedge clk_in) begin
      if (wr_in.we) begin
         mem_q[wr_in.addr] <= wr_in.data;
      end
   end

   // Read data comes straight from a register
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= mem_q[raddr_in];
      end
   end
endmodule : adcph_result_mem
`default_nettype wire

// [hdl/adcph_port.sv]
// Converter host port: strobes, configuration, sequencer, flags, data bus
`default_nettype none
`include "adcph_params.svh"
module adcph_port #(
   parameter int CONV_CYC = `ADCPH_CONV_CYC,
   parameter int NCH      = `ADCPH_CHANNELS
) (
   // Clock and reset
   input  wire logic                       clk_in,
   input  wire logic                       reset_n_in,
   // Host strobes
   input  wire adcph_pkg::adcph_strobe_t   strobe_in,
   input  wire logic                       sample_trigger_in,
   input  wire logic                       idle_channel_powerdown_n_in,
   // Data bus pins
   input  wire logic [`ADCPH_CFG_W-1:0]    data_bus_in,
   output var  adcph_pkg::adcph_bus_out_t  data_bus_out,
   // Status flags
   output var  logic                       eoc_n_out,
   output var  logic                       sequence_done_n_out,
   // Analog side
   input  wire logic [NCH*`ADCPH_DATA_W-1:0] analog_level_in,
   output var  logic [NCH-1:0]             chan_power_out
);
   import adcph_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State
   ////////////////////////////////////////////////////////////////////////

   typedef struct packed {
      adcph_state_t                     st;     // Sequencer state
      logic [`ADCPH_CFG_W-1:0]          cfg;    // Channel selection
      logic [NCH*`ADCPH_DATA_W-1:0]     held;   // Levels frozen at trigger
      logic [`ADCPH_CH_W-1:0]           ch;     // Channel in conversion
      logic [`ADCPH_CNT_W-1:0]          cnt;    // Cycles left on channel
      logic [`ADCPH_CH_W-1:0]           rd_ch;  // Channel shown on bus
      logic                             trig;   // Trigger, last cycle
      logic                             wr;     // Write strobe, last cycle
      logic                             rd;     // Read strobe, last cycle
      logic                             eoc;    // Conversion-done, low act
      logic                             seqd;   // Sequence-done, low act
      adcph_word_t                      oe;     // Bus drive enables
      logic [NCH-1:0]                   pwr;    // Channel power
      adcph_wr_t                        mw;     // Memory write
   } adcph_regs_t;

   adcph_regs_t r_q;                           // Registered state
   adcph_regs_t r_d;                           // Next state
   adcph_word_t rdata;                         // Result on read address

   localparam logic [`ADCPH_CNT_W-1:0] CONV_LAST =
      `ADCPH_CNT_W'(CONV_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   // Channel search
   ////////////////////////////////////////////////////////////////////////

   // First selected channel at or above a start index; also says if any
   function automatic logic [`ADCPH_CH_W:0] next_sel(
      input logic [`ADCPH_CFG_W-1:0] mask,
      input logic [`ADCPH_CH_W:0]    from
   );
      logic [`ADCPH_CH_W:0] res;
      res = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (mask[i] && (`ADCPH_CH_W+1)'(i) >= from) begin
            res = {1'b1, `ADCPH_CH_W'(i)};
         end
      end
      return res;
   endfunction : next_sel

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   ////////////////////////////////////////////////////////////////////////

   // Strobe edges, sequencer and flags
   always_comb begin
      logic                 sel_ok;
      logic                 trig_rise;
      logic                 trig_fall;
      logic [`ADCPH_CH_W:0] nx;
      logic [`ADCPH_CH_W:0] first;
      r_d       = r_q;
      trig_rise = sample_trigger_in && !r_q.trig;
      trig_fall = !sample_trigger_in && r_q.trig;
      sel_ok    = !strobe_in.cs_n;
      first     = next_sel(r_q.cfg, '0);
      nx        = '0;

      r_d.trig  = sample_trigger_in;
      r_d.wr    = strobe_in.wr_n;
      r_d.rd    = strobe_in.rd_n;
      r_d.mw.we = 1'b0;
      // Conversion-done pulse lasts one cycle only
      r_d.eoc   = 1'b1;

      // Drive only while read and select are both low; the low lines are
      // released for host writes since a write never overlaps a read
      r_d.oe = {`ADCPH_DATA_W{sel_ok && !strobe_in.rd_n}};

      // Configuration taken at the rising end of a selected write
      if (sel_ok && strobe_in.wr_n && !r_q.wr) begin
         r_d.cfg = data_bus_in;
      end

      // Unselected inputs only power down while powerdown is asserted
      r_d.pwr = idle_channel_powerdown_n_in ? '1 : r_q.cfg;

      // A completed read moves to the next selected channel, wrapping
      if (sel_ok && strobe_in.rd_n && !r_q.rd) begin
         nx = next_sel(r_q.cfg, {1'b0, r_q.rd_ch} + 1'b1);
         r_d.rd_ch = nx[`ADCPH_CH_W] ? nx[`ADCPH_CH_W-1:0]
                                     : first[`ADCPH_CH_W-1:0];
      end

      // Falling trigger releases both flags, unless a channel finishes in that same cycle
      if (trig_fall) begin
         r_d.eoc  = 1'b1;
         r_d.seqd = 1'b1;
      end

      case (r_q.st)
         // Waiting for a trigger; a trigger mid-conversion is ignored
         ADCPH_IDLE, ADCPH_DONE: begin
            if (trig_rise) begin
               r_d.held = analog_level_in;
               if (first[`ADCPH_CH_W]) begin
                  r_d.st  = ADCPH_CONV;
                  r_d.ch  = first[`ADCPH_CH_W-1:0];
                  r_d.cnt = CONV_LAST;
               end else begin
                  // Nothing selected: the sequence is over at once
                  r_d.st   = ADCPH_DONE;
                  r_d.seqd = 1'b0;
               end
            end
         end
         // Count out one channel, store it, pick the next
         ADCPH_CONV: begin
            if (r_q.cnt != '0) begin
               r_d.cnt = r_q.cnt - 1'b1;
            end else begin
               r_d.mw.we   = 1'b1;
               r_d.mw.addr = r_q.ch;
               r_d.mw.data = r_q.held[r_q.ch*`ADCPH_DATA_W +:
                                      `ADCPH_DATA_W];
               r_d.eoc     = 1'b0;
               nx = next_sel(r_q.cfg, {1'b0, r_q.ch} + 1'b1);
               if (nx[`ADCPH_CH_W] && r_q.ch != `ADCPH_CH_W'(NCH - 1)) begin
                  r_d.ch  = nx[`ADCPH_CH_W-1:0];
                  r_d.cnt = CONV_LAST;
               end else begin
                  // Last channel: results read from the lowest one up
                  r_d.st    = ADCPH_DONE;
                  r_d.seqd  = 1'b0;
                  r_d.rd_ch = first[`ADCPH_CH_W-1:0];
               end
            end
         end
         default: begin
            r_d.st = ADCPH_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   ////////////////////////////////////////////////////////////////////////

   // All control state reset to idle, flags high, bus floating
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         r_q      <= '0;
         r_q.st   <= ADCPH_IDLE;
         r_q.cfg  <= `ADCPH_CFG_RESET;
         r_q.wr   <= 1'b1;
         r_q.rd   <= 1'b1;
         r_q.eoc  <= 1'b1;
         r_q.seqd <= 1'b1;
         r_q.pwr  <= '1;
      end else begin
         r_q <= r_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result storage
   ////////////////////////////////////////////////////////////////////////

   // Results kept apart so the wide array maps onto a RAM
   adcph_result_mem #(
      .DEPTH (NCH),
      .AW    (`ADCPH_CH_W)
   ) u_mem (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .wr_in      (r_q.mw),
      .raddr_in   (r_q.rd_ch),
      .rdata_out  (rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   ////////////////////////////////////////////////////////////////////////

   // Every output is a flop; read data is the memory's output register
   always_comb begin
      data_bus_out.dout   = rdata;
      data_bus_out.oe     = r_q.oe;
      eoc_n_out           = r_q.eoc;
      sequence_done_n_out = r_q.seqd;
      chan_power_out      = r_q.pwr;
   end
endmodule : adcph_port
`default_nettype wire

// [tb/adcph_host.sv]
// Host-side bus model: resolves the shared data lines
`default_nettype none
module adcph_host (
   // Clock and host drive
   input  wire logic                      clk_in,
   input  wire logic [7:0]                drv_data_in,
   input  wire logic                      drv_en_in,
   // Device pin output and enable pair
   input  wire adcph_pkg::adcph_bus_out_t dev_in,
   // Resolved lines
   output var  logic [11:0]               bus_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] idle_q = 12'h5a5;  // Undriven lines toggle, stale data fails

   ////////////////////////////////////////////////////////////////////////
   // Idle pattern follows the inverse of the last level
   always_ff @(posedge clk_in) begin
      idle_q <= ~bus_out;
   end

   // Device wins where enabled; host drives only the low lines
   always_comb begin
      for (int i = 0; i < 12; i++) begin
         if (dev_in.oe[i]) begin
            bus_out[i] = dev_in.dout[i];
         end else if (drv_en_in && i < 8) begin
            bus_out[i] = drv_data_in[i];
         end else begin
            bus_out[i] = idle_q[i];
         end
      end
   end
endmodule : adcph_host
`default_nettype wire

// [tb/adcph_port_chk.sv]
// Pin-level assertions for the converter host port
`default_nettype none
module adcph_port_chk #(
   parameter int CONV_CYC = 25,
   parameter int NCH      = 8
) (
   input wire logic                      clk_in,
   input wire logic                      reset_n_in,
   input wire adcph_pkg::adcph_strobe_t  strobe_in,
   input wire logic                      sample_trigger_in,
   input wire logic                      idle_channel_powerdown_n_in,
   input wire logic [7:0]                data_bus_in,
   input wire adcph_pkg::adcph_bus_out_t data_bus_out,
   input wire logic                      eoc_n_out,
   input wire logic                      sequence_done_n_out,
   input wire logic [NCH*12-1:0]         analog_level_in,
   input wire logic [NCH-1:0]            chan_power_out
);
   localparam int LO = CONV_CYC;
   localparam int HI = CONV_CYC + 1;
   logic busy_q;  // Sequence running, so a fresh trigger is refused
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   // Track a running sequence
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) busy_q <= 1'b0;
      else if ($rose(sample_trigger_in)) busy_q <= 1'b1;
      else if (!sequence_done_n_out) busy_q <= 1'b0;
   end

   sequence s_rd_held;
      (!strobe_in.rd_n && !strobe_in.cs_n && eoc_n_out) [*3];
   endsequence
   sequence s_first_done;
      eoc_n_out [*2] ##[LO:HI] (!eoc_n_out || !sequence_done_n_out);
   endsequence
   property p_float_rd;
      strobe_in.rd_n |=> data_bus_out.oe == 12'h000;
   endproperty
   property p_float_cs;
      strobe_in.cs_n |=> data_bus_out.oe == 12'h000;
   endproperty
   property p_drive;
      !strobe_in.rd_n && !strobe_in.cs_n |=> data_bus_out.oe == 12'hfff;
   endproperty
   property p_eoc_pulse;
      $fell(eoc_n_out) |=> eoc_n_out;
   endproperty
   property p_first_eoc;
      $rose(sample_trigger_in) && !busy_q |-> s_first_done;
   endproperty
   property p_seq_hold;
      !sequence_done_n_out && sample_trigger_in
         && $past(sample_trigger_in) |=> !sequence_done_n_out;
   endproperty
   property p_seq_release;
      !sequence_done_n_out && $fell(sample_trigger_in)
         |-> ##[1:2] sequence_done_n_out;
   endproperty
   property p_power_all;
      idle_channel_powerdown_n_in [*3] |-> chan_power_out == {NCH{1'b1}};
   endproperty
   property p_dout_stable;
      s_rd_held |-> $stable(data_bus_out.dout);
   endproperty
   a_float_rd: assert property (p_float_rd)
      else $error("bus driven while read high");
   a_float_cs: assert property (p_float_cs)
      else $error("bus driven while deselected");
   a_drive: assert property (p_drive)
      else $error("bus not driven on read");
   a_eoc_pulse: assert property (p_eoc_pulse)
      else $error("conversion flag longer than one cycle");
   a_first_eoc: assert property (p_first_eoc)
      else $error("first conversion flag late or early");
   a_seq_hold: assert property (p_seq_hold)
      else $error("sequence flag released early");
   a_seq_release: assert property (p_seq_release)
      else $error("sequence flag not released");
   a_power_all: assert property (p_power_all)
      else $error("channel unpowered with powerdown off");
   a_dout_stable: assert property (p_dout_stable)
      else $error("read data moved during a read");
endmodule : adcph_port_chk
bind adcph_port adcph_port_chk #(.CONV_CYC(CONV_CYC), .NCH(NCH)) i_chk (
   .clk_in(clk_in), .reset_n_in(reset_n_in), .strobe_in(strobe_in),
   .sample_trigger_in(sample_trigger_in),
   .idle_channel_powerdown_n_in(idle_channel_powerdown_n_in),
   .data_bus_in(data_bus_in), .data_bus_out(data_bus_out),
   .eoc_n_out(eoc_n_out), .sequence_done_n_out(sequence_done_n_out),
   .analog_level_in(analog_level_in), .chan_power_out(chan_power_out));
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the converter host port
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import adcph_pkg::*;
   logic           clk_in, reset_n_in, trig, pd_n, eoc_n, sd_n, hen;
   adcph_strobe_t  stb;
   adcph_bus_out_t bo;
   logic [7:0]     hd, pwr;
   logic [11:0]    bus;
   logic [95:0]    lv;
   int             err_total, n_checks;

   // Short conversion count keeps the run brief
   adcph_port #(.CONV_CYC(3)) i_dut (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .strobe_in(stb),
      .sample_trigger_in(trig), .idle_channel_powerdown_n_in(pd_n),
      .data_bus_in(bus[7:0]), .data_bus_out(bo), .eoc_n_out(eoc_n),
      .sequence_done_n_out(sd_n), .analog_level_in(lv),
      .chan_power_out(pwr));
   adcph_host i_host (.clk_in(clk_in), .drv_data_in(hd),
      .drv_en_in(hen), .dev_in(bo), .bus_out(bus));

   ////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : tick
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [11:0] lvl(input int k);
      return 12'h0f0 + 12'(k) * 12'h101;
   endfunction : lvl
   task automatic end_of_test();
      if (err_total == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   // Configuration write; data held through the closing edge
   task automatic t_write(input logic cs, input logic [7:0] v);
      stb.cs_n = cs;
      stb.wr_n = 1'b0;
      hd = v;
      hen = 1'b1;
      tick(2);
      stb.wr_n = 1'b1;
      tick(1);
      stb.cs_n = 1'b1;
      hen = 1'b0;
      tick(1);
   endtask : t_write
   // One read strobe, sampled off the resolved lines
   task automatic t_read(output logic [11:0] d);
      stb.cs_n = 1'b0;
      stb.rd_n = 1'b0;
      tick(3);
      chk(bo.oe, 12'hfff);
      d = bus;
      // Select stays low past the read's rising end so the pointer moves
      stb.rd_n = 1'b1;
      tick(1);
      stb.cs_n = 1'b1;
      tick(1);
      chk(bo.oe, 12'h000);
   endtask : t_read
   // Convert, then read every selected channel and one wrap
   task automatic t_seq(input logic [7:0] cfg);
      int n;
      int k;
      logic [11:0] d;
      logic [11:0] first;
      n = 0;
      first = 12'h000;
      for (k = 0; k < 8; k++) lv[k*12+:12] = lvl(k);
      trig = 1'b1;
      for (k = 0; k < 60 && sd_n; k++) begin
         tick(1);
         if (k == 1) lv = ~lv;  // Late change must not reach results
         if (!eoc_n) n++;
      end
      chk(12'(n), 12'($countones(cfg)));
      tick(2);
      chk(12'(sd_n), 12'h000);
      trig = 1'b0;
      tick(3);
      chk(12'(sd_n), 12'h001);
      for (k = 7; k >= 0; k--) if (cfg[k]) first = lvl(k);
      for (k = 0; k < 8; k++) begin
         if (cfg[k]) begin
            t_read(d);
            chk(d, lvl(k));
         end
      end
      t_read(d);
      chk(d, first);
   endtask : t_seq
   // Powerdown follows the selection, release powers all
   task automatic t_pwr(input logic [7:0] cfg);
      pd_n = 1'b0;
      tick(4);
      chk(12'(pwr), 12'(cfg));
      pd_n = 1'b1;
      tick(4);
      chk(12'(pwr), 12'h0ff);
   endtask : t_pwr

   // Clock
   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // Watchdog
   initial begin
      #20000;
      err_total++;
      end_of_test();
   end
   // Main sequence
   initial begin
      reset_n_in = 1'b0;
      trig = 1'b0;
      pd_n = 1'b1;
      hen = 1'b0;
      hd = 8'h00;
      stb = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
      lv = '0;
      err_total = 0;
      n_checks = 0;
      tick(4);
      chk(bo.oe, 12'h000);
      chk({10'h000, eoc_n, sd_n}, 12'h003);
      reset_n_in = 1'b1;
      tick(1);
      t_seq(8'hff);
      t_write(1'b0, 8'h25);
      t_seq(8'h25);
      t_write(1'b1, 8'h01);
      t_seq(8'h25);
      t_pwr(8'h25);
      t_write(1'b0, 8'h80);
      t_seq(8'h80);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
